// file: core/mrs_pkg.sv
package mrs_pkg;

    // Register byte offsets on the APB window
    localparam logic [11:0] REG_STRAP_OFS   = 12'h000;
    localparam logic [11:0] REG_CTRL_OFS    = 12'h004;
    localparam logic [11:0] REG_STAT_OFS    = 12'h008;

    // Strap status register: fixed bits and their values
    localparam logic [7:0]  STRAP_FIXED_MASK = 8'hFC;
    localparam logic [7:0]  STRAP_FIXED_VAL  = 8'hE4;
    localparam int          STRAP_HI_BIT     = 1;
    localparam int          STRAP_LO_BIT     = 0;

    // Control register fields and reset value
    localparam int          CTRL_RAM_EN_BIT  = 0;
    localparam logic [7:0]  CTRL_RESET       = 8'h01;

    // Status register fields
    localparam int          STAT_CAUSE_EXT_BIT = 0;
    localparam int          STAT_MODE_LO_BIT   = 1;
    localparam int          STAT_RUN_BIT       = 3;

    // Address map of the smallest variant
    localparam logic [15:0] ROM_HI_ADDR     = 16'h7FFF;
    localparam logic [15:0] RSV_LO_ADDR     = 16'hF780;
    localparam logic [15:0] RAM_LO_ADDR     = 16'hFB80;
    localparam logic [15:0] RAM_HI_ADDR     = 16'hFF7F;
    localparam logic [15:0] EXT_WIN_LO_ADDR = 16'hFF80;
    localparam logic [15:0] EXT_WIN_HI_ADDR = 16'hFF87;
    localparam logic [15:0] REG_LO_ADDR     = 16'hFF88;
    localparam logic [15:0] RESET_VEC_ADDR  = 16'h0000;

    // Strap codes {strap_hi, strap_lo}
    localparam logic [1:0]  MODE_EXP_NOROM  = 2'h1;
    localparam logic [1:0]  MODE_EXP_ROM    = 2'h2;
    localparam logic [1:0]  MODE_SINGLE     = 2'h3;

    // Watchdog reset pulse length in system clocks
    localparam int          WDT_PULSE_CLKS  = 518;

    typedef enum logic [2:0] {
        ST_EXT_HOLD,
        ST_WDT_HOLD,
        ST_INIT,
        ST_VEC_FETCH,
        ST_RUN
    } mrs_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } mrs_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } mrs_apb_rsp_t;

endpackage

// file: core/mrs_mode_reset_seq.sv
`timescale 1ns/100ps
module mrs_mode_reset_seq #(
    parameter int WDT_PULSE_CLKS = mrs_pkg::WDT_PULSE_CLKS
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    // APB slave
    input  wire mrs_pkg::mrs_apb_req_t apbReq,
    output      mrs_pkg::mrs_apb_rsp_t apbRsp,
    // Board pins and watchdog
    input  wire logic                  sysRstInN,
    input  wire logic                  strapHi,
    input  wire logic                  strapLo,
    input  wire logic                  wdtRstReq,
    // CPU reset and vector fetch
    output      logic                  cpuHold,
    output      logic                  periphRst,
    output      logic                  condImaskSet,
    output      logic                  vecReq,
    output      logic [15:0]           vecAddr,
    input  wire logic                  vecAck,
    input  wire logic [15:0]           vecData,
    output      logic                  pcLoad,
    output      logic [15:0]           pcValue,
    // Interrupt acceptance
    input  wire logic                  instrEnd,
    input  wire logic                  instrIsFlagOp,
    input  wire logic                  seqEnd,
    input  wire logic                  irqReq,
    input  wire logic                  nmiReq,
    input  wire logic                  cpuImask,
    output      logic                  irqTake,
    output      logic                  irqTakeNmi,
    // Address decode
    input  wire logic [15:0]           cpuAddr,
    output      logic                  selRom,
    output      logic                  selRam,
    output      logic                  selReg,
    output      logic                  selExt
);

    localparam int CW = $clog2(WDT_PULSE_CLKS + 1);
    localparam logic [CW-1:0] WDT_LAST = CW'(WDT_PULSE_CLKS - 1);

    mrs_pkg::mrs_state_t state_q;
    mrs_pkg::mrs_state_t state_d;

    logic [2:0]    rstSync_q;
    logic          rstPinHigh_q;
    logic [2:0]    hiSync_q;
    logic [2:0]    loSync_q;
    logic          hiStable_q;
    logic          loStable_q;
    logic [1:0]    strapRd_q;
    logic [1:0]    mode_q;
    logic [7:0]    ctrl_q;
    logic          causeExt_q;
    logic [CW-1:0] wdtCnt_q;
    logic [31:0]   prdata_q;
    logic          pcLoad_q;
    logic [15:0]   pcValue_q;
    logic          firstDone_q;

    // Reset pin and straps: three flops, a change counts once stages 2 and 3 agree
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rstSync_q <= 3'h0;
            hiSync_q  <= 3'h0;
            loSync_q  <= 3'h0;
        end else begin
            rstSync_q <= {rstSync_q[1:0], sysRstInN};
            hiSync_q  <= {hiSync_q[1:0], strapHi};
            loSync_q  <= {loSync_q[1:0], strapLo};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rstPinHigh_q <= 1'b0;
            hiStable_q   <= 1'b0;
            loStable_q   <= 1'b0;
        end else begin
            if (rstSync_q[1] == rstSync_q[2]) begin
                rstPinHigh_q <= rstSync_q[2];
            end
            if (hiSync_q[1] == hiSync_q[2]) begin
                hiStable_q <= hiSync_q[2];
            end
            if (loSync_q[1] == loSync_q[2]) begin
                loStable_q <= loSync_q[2];
            end
        end
    end

    wire extRstActive = ~rstPinHigh_q;
    wire inWdt        = (state_q == mrs_pkg::ST_WDT_HOLD);
    wire inRun        = (state_q == mrs_pkg::ST_RUN);
    wire wdtDone      = inWdt && (wdtCnt_q == WDT_LAST);

    // Reset sequencer; the pin wins over everything, the watchdog over running code
    always_comb begin
        state_d = state_q;
        if (extRstActive) begin
            state_d = mrs_pkg::ST_EXT_HOLD;
        end else begin
            unique case (state_q)
                mrs_pkg::ST_EXT_HOLD: begin
                    state_d = mrs_pkg::ST_INIT;
                end
                mrs_pkg::ST_WDT_HOLD: begin
                    if (wdtDone) begin
                        state_d = mrs_pkg::ST_INIT;
                    end
                end
                mrs_pkg::ST_INIT: begin
                    state_d = mrs_pkg::ST_VEC_FETCH;
                end
                mrs_pkg::ST_VEC_FETCH: begin
                    if (wdtRstReq) begin
                        state_d = mrs_pkg::ST_WDT_HOLD;
                    end else if (vecAck) begin
                        state_d = mrs_pkg::ST_RUN;
                    end
                end
                mrs_pkg::ST_RUN: begin
                    if (wdtRstReq) begin
                        state_d = mrs_pkg::ST_WDT_HOLD;
                    end
                end
                default: begin
                    state_d = mrs_pkg::ST_EXT_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= mrs_pkg::ST_EXT_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // Pulse width counter; restarts whenever the hold is entered
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !inWdt) begin
            wdtCnt_q <= '0;
        end else if (!wdtDone) begin
            wdtCnt_q <= wdtCnt_q + CW'(1);
        end
    end

    // Reset cause and mode capture; mode is taken once per reset exit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            causeExt_q <= 1'b1;
            mode_q     <= mrs_pkg::MODE_SINGLE;
        end else begin
            if (state_d == mrs_pkg::ST_EXT_HOLD) begin
                causeExt_q <= 1'b1;
            end else if (state_d == mrs_pkg::ST_WDT_HOLD) begin
                causeExt_q <= 1'b0;
            end
            if (state_q == mrs_pkg::ST_INIT) begin
                mode_q <= {hiStable_q, loStable_q};
            end
        end
    end

    // Reset outputs and vector fetch
    assign periphRst    = (state_q == mrs_pkg::ST_EXT_HOLD) || inWdt;
    assign cpuHold      = !inRun;
    assign condImaskSet = (state_q == mrs_pkg::ST_INIT);
    assign vecReq       = (state_q == mrs_pkg::ST_VEC_FETCH) && !extRstActive;
    assign vecAddr      = mrs_pkg::RESET_VEC_ADDR;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pcLoad_q  <= 1'b0;
            pcValue_q <= 16'h0000;
        end else begin
            pcLoad_q <= vecReq && vecAck && !wdtRstReq;
            if (vecReq && vecAck) begin
                pcValue_q <= vecData;
            end
        end
    end

    assign pcLoad  = pcLoad_q;
    assign pcValue = pcValue_q;

    // Interrupt acceptance; only RUN boundaries count, and a sequence end
    // before the first instruction has finished admits nothing, so the
    // instruction that sets up the stack always runs
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !inRun) begin
            firstDone_q <= 1'b0;
        end else if (instrEnd) begin
            firstDone_q <= 1'b1;
        end
    end

    wire boundary   = instrEnd || seqEnd;
    wire flagBlock  = instrEnd && instrIsFlagOp;
    wire rstPending = extRstActive || wdtRstReq;
    wire firstOk    = firstDone_q || instrEnd;
    wire canTake    = inRun && boundary && !flagBlock && !rstPending && firstOk;

    assign irqTakeNmi = canTake && nmiReq;
    assign irqTake    = canTake && (nmiReq || (irqReq && !cpuImask));

    // Address decode
    wire expanded = (mode_q != mrs_pkg::MODE_SINGLE);
    wire ramEn    = ctrl_q[mrs_pkg::CTRL_RAM_EN_BIT];
    wire inRam    = (cpuAddr >= mrs_pkg::RAM_LO_ADDR) && (cpuAddr <= mrs_pkg::RAM_HI_ADDR);
    wire inWin    = (cpuAddr >= mrs_pkg::EXT_WIN_LO_ADDR) && (cpuAddr <= mrs_pkg::EXT_WIN_HI_ADDR);
    wire inRsv    = (cpuAddr >= mrs_pkg::RSV_LO_ADDR) && (cpuAddr < mrs_pkg::RAM_LO_ADDR);
    wire inRomRng = (cpuAddr <= mrs_pkg::ROM_HI_ADDR);

    assign selReg = (cpuAddr >= mrs_pkg::REG_LO_ADDR);
    assign selRam = inRam && (ramEn || !expanded);
    assign selRom = inRomRng && (mode_q != mrs_pkg::MODE_EXP_NOROM);
    assign selExt = expanded && !selReg && !selRam && !selRom && !inRsv
                    && (inWin || inRam || !inRsv);

    // APB slave: zero wait states, read data captured in the setup cycle
    wire        apbSetup = apbReq.psel && !apbReq.penable;
    wire        apbWrEdge = apbReq.psel && apbReq.penable && apbReq.pwrite;
    wire        hitStrap = (apbReq.paddr == mrs_pkg::REG_STRAP_OFS);
    wire        hitCtrl  = (apbReq.paddr == mrs_pkg::REG_CTRL_OFS);
    wire        hitStat  = (apbReq.paddr == mrs_pkg::REG_STAT_OFS);
    wire        strapRead = apbSetup && !apbReq.pwrite && hitStrap;
    wire [1:0]  strapNow = {hiStable_q, loStable_q};
    wire [7:0]  strapWord = (mrs_pkg::STRAP_FIXED_VAL & mrs_pkg::STRAP_FIXED_MASK)
                            | {6'h00, strapNow};
    wire [7:0]  statWord = {4'h0, inRun, mode_q, causeExt_q};
    wire [31:0] rdMux = hitStrap ? {24'h000000, strapWord} :
                        hitCtrl  ? {24'h000000, ctrl_q} :
                        hitStat  ? {24'h000000, statWord} : 32'h00000000;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prdata_q  <= 32'h00000000;
            strapRd_q <= 2'h0;
        end else if (apbSetup) begin
            prdata_q <= apbReq.pwrite ? 32'h00000000 : rdMux;
            if (strapRead) begin
                strapRd_q <= strapNow;
            end
        end
    end

    // Only the RAM enable is writable; strap and status writes are dropped
    always_ff @(posedge clk_sys) begin
        if (sys_rst || periphRst) begin
            ctrl_q <= mrs_pkg::CTRL_RESET;
        end else if (apbWrEdge && hitCtrl) begin
            ctrl_q <= {7'h00, apbReq.pwdata[mrs_pkg::CTRL_RAM_EN_BIT]};
        end
    end

    assign apbRsp.pready  = 1'b1;
    assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !(hitStrap || hitCtrl || hitStat);
    assign apbRsp.prdata  = prdata_q;

    // Checks
    a_strap_fixed: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (apbSetup && !apbReq.pwrite && hitStrap) |=> (prdata_q[7:2] == 6'h39))
        else $error("strap reserved bits read wrong");

    a_strap_latch: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        strapRead |=> (prdata_q[1:0] == $past(strapNow)) && (strapRd_q == $past(strapNow)))
        else $error("strap read did not return pin levels");

    a_strap_nowrite: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (apbWrEdge && hitStrap) |=> $stable(ctrl_q))
        else $error("write to strap register changed state");

    a_pin_priority: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        extRstActive |=> (state_q == mrs_pkg::ST_EXT_HOLD) && periphRst && !irqTake)
        else $error("reset pin did not take priority");

    a_pin_exit: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        ((state_q == mrs_pkg::ST_EXT_HOLD) && !extRstActive) |=>
            condImaskSet ##1 (vecReq || extRstActive))
        else $error("reset exit sequence wrong");

    logic [9:0] wdtSeen_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !inWdt) begin
            wdtSeen_q <= 10'h000;
        end else begin
            wdtSeen_q <= wdtSeen_q + 10'h001;
        end
    end

    a_wdt_width: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        ($fell(inWdt) && (state_q == mrs_pkg::ST_INIT)) |->
            ($past(wdtSeen_q) == 10'(WDT_PULSE_CLKS - 1)))
        else $error("watchdog reset width wrong");

    a_vec_load: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (vecReq && vecAck && !wdtRstReq) |=> pcLoad && (pcValue == $past(vecData)) && inRun)
        else $error("vector not loaded into PC");

    a_flag_block: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (instrEnd && instrIsFlagOp) |-> !irqTake && !irqTakeNmi)
        else $error("interrupt taken after flag op");

    a_irq_boundary: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        irqTake |-> inRun && (instrEnd || seqEnd) && $past(inRun))
        else $error("interrupt outside a run boundary");

    a_first_instr: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (seqEnd && !instrEnd && !firstDone_q) |-> !irqTake && !irqTakeNmi)
        else $error("interrupt taken before first instruction");

    a_ram_decode: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        inRam |-> (selRam != (expanded && !ramEn)) && (selExt == (expanded && !ramEn)))
        else $error("RAM range decode wrong");

endmodule

// file: tb/mrs_board_model.sv
`timescale 1ns/100ps
module mrs_board_model #(
    parameter int POR_CLKS  = 40,
    parameter int HOLD_CLKS = 10
) (
    // Clock
    input  wire logic       clk_sys,
    // Bench control
    input  wire logic       pinRstReq,
    input  wire logic [1:0] strapSel,
    // Board pins
    output      logic       sysRstInN,
    output      logic       strapHi,
    output      logic       strapLo
);
    // Power-on hold is scaled down, the true minimum would dominate the run
    int         holdCnt = POR_CLKS;
    logic [1:0] strapQ  = mrs_pkg::MODE_SINGLE;
    always @(posedge clk_sys) begin
        if (pinRstReq) begin
            holdCnt <= HOLD_CLKS;
        end else if (holdCnt > 0) begin
            holdCnt <= holdCnt - 1;
        end
        // Straps move only under reset and never to the unused code
        if (holdCnt > 0 && strapSel != 2'h0) begin
            strapQ <= strapSel;
        end
    end
    assign sysRstInN = (holdCnt == 0);
    assign {strapHi, strapLo} = strapQ;
endmodule

// file: tb/mode_reset_sequencer_tb.sv
`timescale 1ns/100ps
module mode_reset_sequencer_tb;
    localparam int WDT_LEN = 8;
    // Decode probes: {rom, ram, reg, ext}; last two are the external window
    localparam logic [15:0] ADDRS [6] = '{16'hFB80, 16'hFF7F, 16'hFF88, 16'hFFFF, 16'hFF80, 16'hFF87};
    localparam logic [3:0]  SELS [6]  = '{4'h4, 4'h4, 4'h2, 4'h2, 4'h1, 4'h1};
    // {instrEnd, flagOp, seqEnd, irq, nmi, mask, take, takeNmi}
    localparam logic [7:0]  IRQ_TAB [8] = '{8'h38, 8'h92, 8'hD8, 8'h92, 8'h32, 8'h18, 8'h8B, 8'h94};
    logic                  clk_sys, sys_rst, sysRstInN, strapHi, strapLo, wdtRstReq, vecAck;
    logic                  cpuHold, periphRst, condImaskSet, vecReq, pcLoad, instrEnd, seqEnd;
    logic                  instrIsFlagOp, irqReq, nmiReq, cpuImask, irqTake, irqTakeNmi;
    logic                  selRom, selRam, selReg, selExt, pinRstReq, sawMask, apbErr;
    logic [1:0]            strapSel;
    logic [3:0]            selExp;
    logic [15:0]           vecAddr, vecData, pcValue, cpuAddr;
    logic [31:0]           rdData, strapExp;
    mrs_pkg::mrs_apb_req_t apbReq;
    mrs_pkg::mrs_apb_rsp_t apbRsp;
    int                    mismatches, comparisons, cnt;

    mrs_mode_reset_seq #(.WDT_PULSE_CLKS(WDT_LEN)) mrs_mode_reset_seq_i (
        .clk_sys, .sys_rst, .apbReq, .apbRsp, .sysRstInN, .strapHi, .strapLo, .wdtRstReq,
        .cpuHold, .periphRst, .condImaskSet, .vecReq, .vecAddr, .vecAck, .vecData, .pcLoad,
        .pcValue, .instrEnd, .instrIsFlagOp, .seqEnd, .irqReq, .nmiReq, .cpuImask, .irqTake,
        .irqTakeNmi, .cpuAddr, .selRom, .selRam, .selReg, .selExt);
    mrs_board_model mrs_board_model_i (
        .clk_sys, .pinRstReq, .strapSel, .sysRstInN, .strapHi, .strapLo);

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic tick();
        @(posedge clk_sys);
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Idle cycle at the end keeps two back-to-back calls from driving one edge twice
    task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: adr, pwdata: wd};
        tick();
        apbReq.penable <= 1'b1;
        do begin
            tick();
        end while (apbRsp.pready !== 1'b1);
        rdData = apbRsp.prdata;
        apbErr = apbRsp.pslverr;
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
        tick();
    endtask

    task automatic boot(input logic [15:0] vec);
        for (int i = 0; i < 200 && vecReq !== 1'b1; i++) begin
            tick();
            sawMask |= (condImaskSet === 1'b1);
        end
        chk("imask set", 1, sawMask);
        chk("vector addr", mrs_pkg::RESET_VEC_ADDR, vecAddr);
        vecAck  <= 1'b1;
        vecData <= vec;
        tick();
        vecAck <= 1'b0;
        tick();
        chk("pc load", 1, pcLoad);
        chk("pc value", vec, pcValue);
        chk("cpu hold", 0, cpuHold);
    endtask

    task automatic pinReset(input logic [1:0] m);
        strapSel  <= m;
        pinRstReq <= 1'b1;
        tick();
        pinRstReq <= 1'b0;
        sawMask = 1'b0;
        for (int i = 0; i < 20 && periphRst !== 1'b1; i++) tick();
        chk("periph reset", 1, periphRst);
        chk("hold in reset", 1, cpuHold);
        boot(16'h1000 + 16'(m));
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        $display("[ERR] run time expected done seen timeout");
        end_of_test();
    end

    initial begin
        mismatches = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        apbReq = '0;
        {wdtRstReq, vecAck, instrEnd, instrIsFlagOp, seqEnd, irqReq, nmiReq} = 7'h00;
        {cpuImask, pinRstReq, sawMask} = 3'h0;
        vecData = 16'h0000;
        cpuAddr = 16'h0000;
        strapSel = mrs_pkg::MODE_SINGLE;
        repeat (2) tick();
        sys_rst <= 1'b0;
        boot(16'h0100);
        $display("test power_on done");
        for (int m = 1; m <= 3; m++) begin
            pinReset(2'(m));
            strapExp = {24'h0, mrs_pkg::STRAP_FIXED_VAL | 8'(m)};
            apb(1'b0, mrs_pkg::REG_STRAP_OFS, 32'h0);
            chk("strap reg", strapExp, rdData);
            apb(1'b1, mrs_pkg::REG_STRAP_OFS, ~strapExp);
            apb(1'b0, mrs_pkg::REG_STRAP_OFS, 32'h0);
            chk("strap after write", strapExp, rdData);
            apb(1'b0, mrs_pkg::REG_STAT_OFS, 32'h0);
            chk("status", {1'b1, 2'(m), 1'b1}, rdData[3:0]);
            apb(1'b0, mrs_pkg::REG_CTRL_OFS, 32'h0);
            chk("ctrl reset", mrs_pkg::CTRL_RESET, rdData);
            for (int k = 0; k < 6; k++) begin
                cpuAddr <= ADDRS[k];
                selExp = (m == 3 && k > 3) ? 4'h0 : SELS[k];
                tick();
                chk("decode", selExp, {selRom, selRam, selReg, selExt});
            end
            // Low program space: external in mode 1, on-chip ROM otherwise
            cpuAddr <= 16'h0100;
            selExp = (m == 1) ? 4'h1 : 4'h8;
            tick();
            chk("rom decode", selExp, {selRom, selRam, selReg, selExt});
            if (m == 1) begin
                apb(1'b1, mrs_pkg::REG_CTRL_OFS, 32'h0);
                cpuAddr <= mrs_pkg::RAM_LO_ADDR;
                tick();
                chk("ram off decode", 4'h1, {selRom, selRam, selReg, selExt});
            end
            $display("test mode_%0d done", m);
        end
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped err", 1, apbErr);
        chk("unmapped data", 0, rdData);
        for (int k = 0; k < 8; k++) begin
            {instrEnd, instrIsFlagOp, seqEnd, irqReq, nmiReq, cpuImask} <= IRQ_TAB[k][7:2];
            tick();
            chk("irq take", IRQ_TAB[k][1:0], {irqTake, irqTakeNmi});
            {instrEnd, instrIsFlagOp, seqEnd, cpuImask} <= 4'h0;
            tick();
        end
        $display("test interrupts done");
        {instrEnd, irqReq, nmiReq, wdtRstReq} <= 4'hF;
        tick();
        chk("irq during wdt", 2'h0, {irqTake, irqTakeNmi});
        {instrEnd, irqReq, nmiReq, wdtRstReq} <= 4'h0;
        cnt = 0;
        tick();
        while (periphRst === 1'b1 && cnt < 1000) begin
            cnt++;
            tick();
        end
        chk("wdt hold", WDT_LEN, cnt);
        chk("init after wdt", 1, condImaskSet);
        sawMask = (condImaskSet === 1'b1);
        boot(16'h2000);
        apb(1'b0, mrs_pkg::REG_STAT_OFS, 32'h0);
        chk("wdt cause", 0, rdData[mrs_pkg::STAT_CAUSE_EXT_BIT]);
        $display("test watchdog done");
        end_of_test();
    end
endmodule
